// File: dio_space.sv
// Top of the controller-wide digital point space: 256 inputs, 256 outputs.
// Assumes all inputs are synchronous to core_clk; one point access per port per cycle.
`timescale 1ns/1ps

module dio_space
    import dio_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Output point access command
    input wire logic outCmdValid,
    input wire logic outCmdWrite,
    input wire logic [7:0] outCmdIndex,
    input wire logic outCmdValue,
    output logic outRdValid,
    output logic outRdData,
    // Input point access
    input wire logic inCmdValid,
    input wire logic inCmdWrite,
    input wire logic [7:0] inCmdIndex,
    input wire logic inCmdValue,
    output logic inRdValid,
    output logic inRdData,
    // Mapping to PLC memory, one enable per 16-point word
    input wire logic [15:0] outMapEn,
    input wire logic [15:0] inMapEn,
    // PLC memory exchange
    input wire logic plcOutRdValid,
    input wire logic [3:0] plcOutRdWord,
    output logic plcOutRdDone,
    output logic [15:0] plcOutRdData,
    input wire logic plcInWrValid,
    input wire logic [3:0] plcInWrWord,
    input wire logic [15:0] plcInWrData,
    // Fieldbus drive signals
    input wire logic driveLinkUp,
    input wire logic [15:0] driveIn,
    // Front connector
    output logic [7:0] fieldOut,
    input wire logic [15:0] fieldIn
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    dio_store_if st ();

    logic [7:0] physOut_reg;
    logic outRdData_reg;
    logic inRdData_reg;
    logic plcOutRdDone_reg;
    logic [15:0] plcOutRdData_reg;
    dio_rsp_e rsp_reg;
    dio_rsp_e rsp_next;

    logic outWrite;
    logic outRead;
    logic inRead;
    logic inWriteSoft;
    logic inWordMapped;
    logic driveWordLive;
    logic outSelBit;
    logic inRdBit;
    logic plcInAllowed;

    // ----------------------------------------
    // Store instance
    // ----------------------------------------
    dio_vstore dio_vstore_inst (
        .core_clk(core_clk),
        .resetn(resetn),
        .st(st)
    );

    // ----------------------------------------
    // Command decode
    // ----------------------------------------
    // Indices are global; there is no axis selector anywhere in the path
    assign outWrite = outCmdValid && outCmdWrite;
    assign outRead = outCmdValid && !outCmdWrite;
    assign inRead = inCmdValid && !inCmdWrite;

    // Drive signals own word 1 only while the fieldbus link is up
    assign driveWordLive = driveLinkUp;
    assign inWordMapped = inMapEn[inCmdIndex[7:4]];

    // Software may only set virtual inputs that nobody else feeds
    always_comb begin
        inWriteSoft = 1'b0;
        if (inCmdValid && inCmdWrite && inCmdIndex >= DIO_VIRT_FIRST && !inWordMapped) begin
            inWriteSoft = 1'b1;
            if (driveWordLive && inCmdIndex <= DIO_DRIVE_IN_LAST) begin
                inWriteSoft = 1'b0;
            end
        end
    end

    // PLC writes land only in mapped words above the physical word
    always_comb begin
        plcInAllowed = 1'b0;
        if (plcInWrValid && plcInWrWord != 4'h0 && inMapEn[plcInWrWord]) begin
            plcInAllowed = 1'b1;
            if (driveWordLive && plcInWrWord == DIO_DRIVE_WORD) begin
                plcInAllowed = 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Store bundle drive
    // ----------------------------------------
    assign st.outWr = outWrite && outCmdIndex >= DIO_VIRT_FIRST;
    assign st.outWrIdx = outCmdIndex;
    assign st.outWrVal = outCmdValue;
    assign st.inWr = inWriteSoft;
    assign st.inWrIdx = inCmdIndex;
    assign st.inWrVal = inCmdValue;
    assign st.plcInWr = plcInAllowed;
    assign st.plcInWord = plcInWrWord;
    assign st.plcInData = plcInWrData;
    assign st.outRdIdx = outCmdIndex;
    assign st.inRdIdx = inCmdIndex;
    assign st.plcOutWord = plcOutRdWord;

    // ----------------------------------------
    // Physical outputs 8..15
    // ----------------------------------------
    // Writes to 0..7 fall through every branch and change nothing
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            physOut_reg <= DIO_PHYS_OUT_RESET;
        end else if (outWrite && outCmdIndex >= DIO_PHYS_OUT_FIRST
                     && outCmdIndex <= DIO_PHYS_OUT_LAST) begin
            physOut_reg[outCmdIndex[2:0]] <= outCmdValue;
        end
    end

    assign fieldOut = physOut_reg;

    // ----------------------------------------
    // Read selection
    // ----------------------------------------
    always_comb begin
        if (outCmdIndex <= DIO_PHANTOM_LAST) begin
            outSelBit = 1'b0;
        end else if (outCmdIndex <= DIO_PHYS_OUT_LAST) begin
            outSelBit = physOut_reg[outCmdIndex[2:0]];
        end else begin
            outSelBit = st.outRdBit;
        end
    end

    always_comb begin
        if (inCmdIndex <= DIO_PHYS_IN_LAST) begin
            inRdBit = fieldIn[inCmdIndex[3:0]];
        end else if (driveWordLive && inCmdIndex <= DIO_DRIVE_IN_LAST) begin
            // Bit 0 is the forward limit at 16, bit 1 the reverse limit at 17
            inRdBit = driveIn[inCmdIndex[3:0]];
        end else begin
            inRdBit = st.inRdBit;
        end
    end

    // ----------------------------------------
    // Response registers
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            outRdData_reg <= 1'b0;
        end else if (outRead) begin
            outRdData_reg <= outSelBit;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            inRdData_reg <= 1'b0;
        end else if (inRead) begin
            inRdData_reg <= inRdBit;
        end
    end

    // Unmapped or physical words answer zero so the PLC never sees private state
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            plcOutRdDone_reg <= 1'b0;
            plcOutRdData_reg <= DIO_WORD_RESET;
        end else begin
            plcOutRdDone_reg <= plcOutRdValid;
            if (plcOutRdValid) begin
                if (plcOutRdWord != 4'h0 && outMapEn[plcOutRdWord]) begin
                    plcOutRdData_reg <= st.plcOutData;
                end else begin
                    plcOutRdData_reg <= DIO_WORD_RESET;
                end
            end
        end
    end

    // ----------------------------------------
    // Response kind tracking
    // ----------------------------------------
    always_comb begin
        case ({outRead, inRead})
            2'b10: rsp_next = DIO_RSP_OUT;
            2'b01: rsp_next = DIO_RSP_IN;
            2'b11: rsp_next = DIO_RSP_BOTH;
            default: rsp_next = DIO_RSP_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rsp_reg <= DIO_RSP_IDLE;
        end else begin
            rsp_reg <= rsp_next;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign outRdValid = rsp_reg == DIO_RSP_OUT || rsp_reg == DIO_RSP_BOTH;
    assign outRdData = outRdData_reg;
    assign inRdValid = rsp_reg == DIO_RSP_IN || rsp_reg == DIO_RSP_BOTH;
    assign inRdData = inRdData_reg;
    assign plcOutRdDone = plcOutRdDone_reg;
    assign plcOutRdData = plcOutRdData_reg;

endmodule : dio_space

// File: dio_pkg.sv
// Constants and types for the controller-wide digital point space.
// Assumes a single core clock domain; no software-reachable registers.
package dio_pkg;

    // ----------------------------------------
    // Point space geometry
    // ----------------------------------------
    localparam int DIO_POINTS = 256;
    localparam int DIO_IDX_W = 8;
    localparam int DIO_WORD_W = 16;
    localparam int DIO_WORD_SEL_W = 4;
    localparam int DIO_WORDS = 16;

    // ----------------------------------------
    // Index ranges
    // ----------------------------------------
    localparam logic [7:0] DIO_PHANTOM_LAST = 8'h07;
    localparam logic [7:0] DIO_PHYS_OUT_FIRST = 8'h08;
    localparam logic [7:0] DIO_PHYS_OUT_LAST = 8'h0F;
    localparam logic [7:0] DIO_PHYS_IN_LAST = 8'h0F;
    localparam logic [7:0] DIO_VIRT_FIRST = 8'h10;
    localparam logic [7:0] DIO_DRIVE_IN_LAST = 8'h1F;
    localparam logic [7:0] DIO_FWD_LIMIT_IDX = 8'h10;
    localparam logic [7:0] DIO_REV_LIMIT_IDX = 8'h11;
    localparam logic [3:0] DIO_DRIVE_WORD = 4'h1;
    localparam int DIO_PHYS_OUT_COUNT = 8;
    localparam int DIO_PHYS_IN_COUNT = 16;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [15:0] DIO_WORD_RESET = 16'h0000;
    localparam logic [7:0] DIO_PHYS_OUT_RESET = 8'h00;

    // ----------------------------------------
    // Response kind of the reads accepted in the previous cycle
    // ----------------------------------------
    typedef enum logic [3:0] {
        DIO_RSP_IDLE = 4'h1,
        DIO_RSP_OUT = 4'h2,
        DIO_RSP_IN = 4'h4,
        DIO_RSP_BOTH = 4'h8
    } dio_rsp_e;

endpackage : dio_pkg

// File: dio_store_if.sv
// Bundle between the point-space top and its virtual point store.
// Assumes both ends run on core_clk.
`timescale 1ns/1ps
interface dio_store_if;
    import dio_pkg::*;

    logic outWr;
    logic [7:0] outWrIdx;
    logic outWrVal;
    logic inWr;
    logic [7:0] inWrIdx;
    logic inWrVal;
    logic plcInWr;
    logic [3:0] plcInWord;
    logic [15:0] plcInData;
    logic [7:0] outRdIdx;
    logic outRdBit;
    logic [7:0] inRdIdx;
    logic inRdBit;
    logic [3:0] plcOutWord;
    logic [15:0] plcOutData;

    modport top (
        output outWr, outWrIdx, outWrVal, inWr, inWrIdx, inWrVal,
        output plcInWr, plcInWord, plcInData, outRdIdx, inRdIdx, plcOutWord,
        input outRdBit, inRdBit, plcOutData
    );
    modport store (
        input outWr, outWrIdx, outWrVal, inWr, inWrIdx, inWrVal,
        input plcInWr, plcInWord, plcInData, outRdIdx, inRdIdx, plcOutWord,
        output outRdBit, inRdBit, plcOutData
    );
endinterface : dio_store_if

// File: dio_vstore.sv
// Word store for virtual output and input points 16..255.
// Assumes the top only issues writes that are legal for the mapping state.
`timescale 1ns/1ps
module dio_vstore
    import dio_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Access bundle
    dio_store_if.store st
);

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    logic [15:0] outWords_reg [DIO_WORDS];
    logic [15:0] inWords_reg [DIO_WORDS];

    genvar w;
    generate
        for (w = 0; w < DIO_WORDS; w++) begin : gWord
            always_ff @(posedge core_clk or negedge resetn) begin
                if (!resetn) begin
                    outWords_reg[w] <= DIO_WORD_RESET;
                end else if (st.outWr && st.outWrIdx[7:4] == 4'(w)) begin
                    outWords_reg[w][st.outWrIdx[3:0]] <= st.outWrVal;
                end
            end
            always_ff @(posedge core_clk or negedge resetn) begin
                if (!resetn) begin
                    inWords_reg[w] <= DIO_WORD_RESET;
                end else if (st.plcInWr && st.plcInWord == 4'(w)) begin
                    inWords_reg[w] <= st.plcInData;
                end else if (st.inWr && st.inWrIdx[7:4] == 4'(w)) begin
                    inWords_reg[w][st.inWrIdx[3:0]] <= st.inWrVal;
                end
            end
        end
    endgenerate

    // Word 0 is never written by the top, which serves it from pins; it stays at reset

    // ----------------------------------------
    // Reads
    // ----------------------------------------
    assign st.outRdBit = outWords_reg[st.outRdIdx[7:4]][st.outRdIdx[3:0]];
    assign st.inRdBit = inWords_reg[st.inRdIdx[7:4]][st.inRdIdx[3:0]];
    assign st.plcOutData = outWords_reg[st.plcOutWord];

endmodule : dio_vstore

// File: dio_space_monitor.sv
// Checker on the ports of the digital point-space top.
// Assumes one core_clk domain and active-low asynchronous resetn.
`timescale 1ns/1ps
module dio_space_monitor
    import dio_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Point access
    input wire logic outCmdValid,
    input wire logic outCmdWrite,
    input wire logic [7:0] outCmdIndex,
    input wire logic outCmdValue,
    input wire logic outRdValid,
    input wire logic outRdData,
    input wire logic inCmdValid,
    input wire logic inCmdWrite,
    input wire logic [7:0] inCmdIndex,
    input wire logic inRdData,
    // PLC side
    input wire logic [15:0] outMapEn,
    input wire logic plcOutRdValid,
    input wire logic [3:0] plcOutRdWord,
    input wire logic plcOutRdDone,
    input wire logic [15:0] plcOutRdData,
    // Field side
    input wire logic driveLinkUp,
    input wire logic [15:0] driveIn,
    input wire logic [7:0] fieldOut,
    input wire logic [15:0] fieldIn
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    logic outRd;
    logic inRd;
    logic expOut;
    logic expIn;
    assign outRd = outCmdValid && !outCmdWrite;
    assign inRd = inCmdValid && !inCmdWrite;
    // Levels as seen at the request edge
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            expOut <= 1'b0;
            expIn <= 1'b0;
        end else begin
            expOut <= fieldOut[outCmdIndex[2:0]];
            expIn <= inCmdIndex[4] ? driveIn[inCmdIndex[3:0]] : fieldIn[inCmdIndex[3:0]];
        end
    end
    AST_OUT_ANSWER: assert property (outRd |=> outRdValid)
        else $error("output read not answered");
    AST_OUT_QUIET: assert property (!outRd |=> !outRdValid)
        else $error("output answer without read");
    AST_PHANTOM: assert property (outRd && outCmdIndex <= DIO_PHANTOM_LAST |=> !outRdData)
        else $error("phantom output read nonzero");
    AST_PHYS_DRIVE: assert property (outCmdValid && outCmdWrite && outCmdIndex inside {[8:15]}
        |=> fieldOut[$past(outCmdIndex[2:0])] == $past(outCmdValue))
        else $error("physical output not driven");
    AST_FIELD_HOLD: assert property (!(outCmdValid && outCmdWrite
        && outCmdIndex inside {[8:15]}) |=> $stable(fieldOut))
        else $error("physical outputs changed without write");
    AST_PHYS_READ: assert property (outRd && outCmdIndex inside {[8:15]}
        |=> outRdData == expOut)
        else $error("physical output read wrong");
    AST_FIELD_IN: assert property (inRd && inCmdIndex <= 8'h0F |=> inRdData == expIn)
        else $error("physical input read wrong");
    AST_DRIVE_IN: assert property (inRd && driveLinkUp && inCmdIndex inside {[16:31]}
        |=> inRdData == expIn)
        else $error("drive input read wrong");
    AST_PLC_DONE: assert property (plcOutRdValid |=> plcOutRdDone)
        else $error("PLC read not answered");
    AST_PLC_UNMAPPED: assert property (plcOutRdValid && (plcOutRdWord == 4'h0
        || !outMapEn[plcOutRdWord]) |=> plcOutRdData == 16'h0000)
        else $error("unmapped PLC word nonzero");
    COV_PHYS: cover property (outCmdValid && outCmdWrite && outCmdIndex == 8'h0F);
    COV_DRIVE: cover property (inRd && driveLinkUp && inCmdIndex == 8'h11);
    COV_PLC: cover property (plcOutRdValid && outMapEn[plcOutRdWord]);
endmodule : dio_space_monitor

bind dio_space dio_space_monitor dio_space_monitor_inst (.core_clk, .resetn, .outCmdValid,
    .outCmdWrite, .outCmdIndex, .outCmdValue, .outRdValid, .outRdData, .inCmdValid,
    .inCmdWrite,
    .inCmdIndex, .inRdData, .outMapEn, .plcOutRdValid, .plcOutRdWord, .plcOutRdDone,
    .plcOutRdData, .driveLinkUp, .driveIn, .fieldOut, .fieldIn);

// File: dio_field_model.sv
// Front terminals and drive link as seen by the point space.
// Assumes the bench sets wanted levels; lines move at falling edges.
`timescale 1ns/1ps
module dio_field_model (
    // Clock
    input wire logic core_clk,
    // Wanted levels
    input wire logic [15:0] fieldSet,
    input wire logic linkSet,
    input wire logic [15:0] driveSet,
    // Terminals and link
    output logic [15:0] fieldIn,
    output logic driveLinkUp,
    output logic [15:0] driveIn
);
    initial begin
        fieldIn = 16'h0000;
        driveLinkUp = 1'b0;
        driveIn = 16'h5A5A;
    end
    // Released drive lines toggle so a stale value never passes for data
    always @(negedge core_clk) begin
        fieldIn <= fieldSet;
        driveLinkUp <= linkSet;
        driveIn <= linkSet ? driveSet : ~driveIn;
    end
endmodule : dio_field_model

// File: dio_space_tb.sv
// Self-checking bench for the digital point-space top.
// Assumes the field model stands at the front terminals and drive link.
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin err_count++; \
    $display("[FAIL] t=%0t act=%0h exp=%0h", $time, a, e); end end
module dio_space_tb;
    import dio_pkg::*;
    logic core_clk, resetn, outCmdValid, outCmdWrite, outCmdValue, outRdValid, outRdData;
    logic inCmdValid, inCmdWrite, inCmdValue, inRdValid, inRdData, plcOutRdValid;
    logic plcOutRdDone, plcInWrValid, driveLinkUp, linkSet, d;
    logic [7:0] outCmdIndex, inCmdIndex, fieldOut;
    logic [3:0] plcOutRdWord, plcInWrWord;
    logic [15:0] outMapEn, inMapEn, plcOutRdData, plcInWrData, driveIn, fieldIn;
    logic [15:0] fieldSet, driveSet, w;
    int err_count, tests_run;

    dio_space dio_space_inst (.core_clk, .resetn, .outCmdValid, .outCmdWrite, .outCmdIndex,
        .outCmdValue, .outRdValid, .outRdData, .inCmdValid, .inCmdWrite, .inCmdIndex,
        .inCmdValue, .inRdValid, .inRdData, .outMapEn, .inMapEn, .plcOutRdValid,
        .plcOutRdWord, .plcOutRdDone, .plcOutRdData, .plcInWrValid, .plcInWrWord,
        .plcInWrData, .driveLinkUp, .driveIn, .fieldOut, .fieldIn);
    dio_field_model dio_field_model_inst (.core_clk, .fieldSet, .linkSet, .driveSet,
        .fieldIn, .driveLinkUp, .driveIn);

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // Requests are raised at a falling edge and held across one rising edge;
    // each call first lets an idle edge pass so valid never drops and rises at once
    task automatic out_cmd(input logic wr, input logic [7:0] idx, input logic v);
        @(negedge core_clk);
        outCmdValid = 1'b1;
        outCmdWrite = wr;
        outCmdIndex = idx;
        outCmdValue = v;
        @(negedge core_clk);
        outCmdValid = 1'b0;
    endtask : out_cmd
    task automatic out_read(input logic [7:0] idx);
        out_cmd(1'b0, idx, 1'b0);
        `CHK(outRdValid, 1'b1)
        d = outRdData;
    endtask : out_read
    task automatic in_cmd(input logic wr, input logic [7:0] idx, input logic v);
        @(negedge core_clk);
        inCmdValid = 1'b1;
        inCmdWrite = wr;
        inCmdIndex = idx;
        inCmdValue = v;
        @(negedge core_clk);
        inCmdValid = 1'b0;
    endtask : in_cmd
    task automatic in_read(input logic [7:0] idx);
        in_cmd(1'b0, idx, 1'b0);
        `CHK(inRdValid, 1'b1)
        d = inRdData;
    endtask : in_read
    task automatic plc_read(input logic [3:0] wd);
        @(negedge core_clk);
        plcOutRdValid = 1'b1;
        plcOutRdWord = wd;
        @(negedge core_clk);
        plcOutRdValid = 1'b0;
        `CHK(plcOutRdDone, 1'b1)
        w = plcOutRdData;
    endtask : plc_read

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        `CHK(fieldOut, 8'h00)
        out_read(8'hFF);
        `CHK(d, 1'b0)
        in_read(8'h80);
        `CHK(d, 1'b0)
        $display("test reset done");
    endtask : t_reset
    task automatic t_outputs;
        for (int i = 0; i < 16; i++) out_cmd(1'b1, 8'(i), i[0]);
        `CHK(fieldOut, 8'hAA)
        out_cmd(1'b1, 8'h02, 1'b1);
        `CHK(fieldOut, 8'hAA)
        for (int i = 0; i < 16; i++) begin
            out_read(8'(i));
            `CHK(d, (i > 7) ? i[0] : 1'b0)
        end
        out_cmd(1'b1, 8'h10, 1'b1);
        out_cmd(1'b1, 8'hFF, 1'b1);
        out_cmd(1'b1, 8'h11, 1'b0);
        out_read(8'h10);
        `CHK(d, 1'b1)
        out_read(8'hFF);
        `CHK(d, 1'b1)
        out_read(8'h11);
        `CHK(d, 1'b0)
        `CHK(fieldOut, 8'hAA)
        $display("test outputs done");
    endtask : t_outputs
    task automatic t_inputs;
        fieldSet = 16'hA5C3;
        linkSet = 1'b1;
        driveSet = 16'h0002;
        repeat (2) @(negedge core_clk);
        for (int i = 0; i < 16; i++) begin
            in_read(8'(i));
            `CHK(d, fieldSet[i])
        end
        in_cmd(1'b1, 8'h11, 1'b1);
        in_read(8'h10);
        `CHK(d, 1'b0)
        in_read(8'h11);
        `CHK(d, 1'b1)
        linkSet = 1'b0;
        repeat (2) @(negedge core_clk);
        in_read(8'h11);
        `CHK(d, 1'b0)
        in_cmd(1'b1, 8'h11, 1'b1);
        in_read(8'h11);
        `CHK(d, 1'b1)
        in_cmd(1'b1, 8'h11, 1'b0);
        in_read(8'h11);
        `CHK(d, 1'b0)
        $display("test inputs done");
    endtask : t_inputs
    task automatic t_plc;
        outMapEn = 16'h0004;
        inMapEn = 16'h0010;
        out_cmd(1'b1, 8'h20, 1'b1);
        out_cmd(1'b1, 8'h2F, 1'b1);
        plc_read(4'h2);
        `CHK(w, 16'h8001)
        out_cmd(1'b1, 8'h30, 1'b1);
        plc_read(4'h3);
        `CHK(w, 16'h0000)
        plcInWrValid = 1'b1;
        plcInWrWord = 4'h4;
        plcInWrData = 16'h0020;
        @(negedge core_clk);
        plcInWrValid = 1'b0;
        in_cmd(1'b1, 8'h45, 1'b0);
        in_read(8'h45);
        `CHK(d, 1'b1)
        $display("test plc done");
    endtask : t_plc

    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : complete_run

    initial begin
        repeat (5000) @(posedge core_clk);
        err_count++;
        complete_run;
    end
    initial begin
        {resetn, outCmdValid, outCmdWrite, outCmdValue, inCmdValid, inCmdWrite} = '0;
        {inCmdValue, plcOutRdValid, plcInWrValid, linkSet} = '0;
        {outCmdIndex, inCmdIndex, plcOutRdWord, plcInWrWord} = '0;
        {outMapEn, inMapEn, plcInWrData, fieldSet, driveSet} = '0;
        repeat (5) @(negedge core_clk);
        resetn = 1'b1;
        t_reset;
        t_outputs;
        t_inputs;
        t_plc;
        complete_run;
    end
endmodule : dio_space_tb
